// file: csrf_defs.svh
/*
  Register offsets, bit positions, reset values and sizes of the colour
  sensor register file. Included by bare name; definitions only.
*/
`ifndef CSRF_DEFS_SVH
`define CSRF_DEFS_SVH

`define CSRF_CHANNELS       4
`define CSRF_CAP_W          4
`define CSRF_SLOT_W         12
`define CSRF_RES_W          10
`define CSRF_OFS_W          8

`define CSRF_ADDR_CMD       8'h00
`define CSRF_ADDR_CFG       8'h01
`define CSRF_CAP_BASE       8'h06
`define CSRF_INT_BASE       8'h0a
`define CSRF_DATA_BASE      8'h40
`define CSRF_OFS_BASE       8'h48

`define CSRF_CMD_CONV_BIT   0
`define CSRF_CMD_OFS_BIT    1
`define CSRF_CFG_TRIM_BIT   0
`define CSRF_CFG_SLEEP_BIT  1
`define CSRF_CFG_EXT_BIT    2

`define CSRF_CAP_RESET      4'hf
`define CSRF_SLOT_RESET     12'h000
`define CSRF_RES_RESET      10'h000
`define CSRF_OFS_RESET      8'h00
`define CSRF_BYTE_ZERO      8'h00

`define CSRF_BIT_CNT_RESET  4'h0
`define CSRF_BIT_CNT_LAST   4'h7
`define CSRF_BIT_CNT_FULL   4'h8
`define CSRF_PTR_STEP       8'h01
`define CSRF_DEV_ADDR       7'h2a

`endif

// file: csrf_pkg.sv
/*
  Types of the colour sensor register file: channel settings, measurement
  results and state encodings. Assumes csrf_defs.svh is on the include path.
*/
`include "csrf_defs.svh"

package csrf_pkg;

  typedef struct packed {
    logic                                          ext_clk;
    logic                                          sleep;
    logic                                          trim;
    logic [`CSRF_CHANNELS-1:0][`CSRF_CAP_W-1:0]    cap;
    logic [`CSRF_CHANNELS-1:0][`CSRF_SLOT_W-1:0]   slots;
  } csrf_setup_t;

  typedef struct packed {
    logic [`CSRF_CHANNELS-1:0][`CSRF_RES_W-1:0]    result;
    logic [`CSRF_CHANNELS-1:0][`CSRF_OFS_W-1:0]    offset;
  } csrf_meas_t;

  typedef enum logic [1:0] {
    CSRF_SEQ_IDLE,
    CSRF_SEQ_CONV,
    CSRF_SEQ_OFS
  } csrf_seq_t;

  typedef enum logic [2:0] {
    CSRF_SER_IDLE,
    CSRF_SER_ADDR,
    CSRF_SER_ADDR_ACK,
    CSRF_SER_WR_BYTE,
    CSRF_SER_WR_ACK,
    CSRF_SER_RD_BYTE,
    CSRF_SER_RD_ACK
  } csrf_ser_t;

endpackage

// file: csrf_serial_slave.sv
/*
  Two-wire serial slave: address byte, register pointer byte, then data
  bytes with auto-increment, reads from the pointer with auto-increment.
  Assumes scl/sda samples already synchronous to core_clk and a clock far
  faster than the serial bit rate.
*/
`timescale 1ns/1ps
`include "csrf_defs.svh"

module csrf_serial_slave #(
  parameter logic [6:0] DEV_ADDR = `CSRF_DEV_ADDR
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Register access
  output logic             wr_pulse,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data
);

  csrf_pkg::csrf_ser_t state_r, state_nxt;
  logic       scl_q_r, scl_q_nxt;
  logic       sda_q_r, sda_q_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic       first_r, first_nxt;
  logic       rw_r, rw_nxt;
  logic       nack_r, nack_nxt;
  logic       oe_r, oe_nxt;
  logic       wr_r, wr_nxt;
  logic [7:0] waddr_r, waddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic       scl_rise, scl_fall, start_seen, stop_seen;

  assign scl_rise   = scl_in & ~scl_q_r;
  assign scl_fall   = ~scl_in & scl_q_r;
  assign start_seen = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_seen  = scl_in & scl_q_r & ~sda_q_r & sda_in;

  always_comb begin
    state_nxt = state_r;
    scl_q_nxt = scl_in;
    sda_q_nxt = sda_in;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    first_nxt = first_r;
    rw_nxt    = rw_r;
    nack_nxt  = nack_r;
    oe_nxt    = oe_r;
    wr_nxt    = 1'b0;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    if (start_seen) begin
      state_nxt = csrf_pkg::CSRF_SER_ADDR;
      cnt_nxt   = `CSRF_BIT_CNT_RESET;
      first_nxt = 1'b1;
      oe_nxt    = 1'b0;
    end else if (stop_seen) begin
      state_nxt = csrf_pkg::CSRF_SER_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      unique case (state_r)
        csrf_pkg::CSRF_SER_IDLE: begin
        end
        csrf_pkg::CSRF_SER_ADDR, csrf_pkg::CSRF_SER_WR_BYTE: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_in};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `CSRF_BIT_CNT_FULL) begin
            if (state_r == csrf_pkg::CSRF_SER_ADDR) begin
              // Foreign addresses are left alone, no acknowledge
              if (shift_r[7:1] == DEV_ADDR) begin
                state_nxt = csrf_pkg::CSRF_SER_ADDR_ACK;
                oe_nxt    = 1'b1;
                rw_nxt    = shift_r[0];
              end else begin
                state_nxt = csrf_pkg::CSRF_SER_IDLE;
              end
            end else begin
              state_nxt = csrf_pkg::CSRF_SER_WR_ACK;
              oe_nxt    = 1'b1;
              if (first_r) begin
                ptr_nxt   = shift_r;
                first_nxt = 1'b0;
              end else begin
                wr_nxt    = 1'b1;
                waddr_nxt = ptr_r;
                wdata_nxt = shift_r;
                ptr_nxt   = ptr_r + `CSRF_PTR_STEP;
              end
            end
          end
        end
        csrf_pkg::CSRF_SER_ADDR_ACK, csrf_pkg::CSRF_SER_WR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = `CSRF_BIT_CNT_RESET;
            if (state_r == csrf_pkg::CSRF_SER_ADDR_ACK && rw_r) begin
              state_nxt = csrf_pkg::CSRF_SER_RD_BYTE;
              shift_nxt = rd_data;
              oe_nxt    = ~rd_data[7];
              ptr_nxt   = ptr_r + `CSRF_PTR_STEP;
            end else begin
              state_nxt = csrf_pkg::CSRF_SER_WR_BYTE;
              oe_nxt    = 1'b0;
            end
          end
        end
        csrf_pkg::CSRF_SER_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_r == `CSRF_BIT_CNT_LAST) begin
              state_nxt = csrf_pkg::CSRF_SER_RD_ACK;
              oe_nxt    = 1'b0;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt    = ~shift_r[6];
              cnt_nxt   = cnt_r + 4'h1;
            end
          end
        end
        csrf_pkg::CSRF_SER_RD_ACK: begin
          if (scl_rise) begin
            nack_nxt = sda_in;
          end else if (scl_fall) begin
            // Master's nack ends the read; wait for stop or restart
            if (nack_r) begin
              state_nxt = csrf_pkg::CSRF_SER_IDLE;
            end else begin
              state_nxt = csrf_pkg::CSRF_SER_RD_BYTE;
              cnt_nxt   = `CSRF_BIT_CNT_RESET;
              shift_nxt = rd_data;
              oe_nxt    = ~rd_data[7];
              ptr_nxt   = ptr_r + `CSRF_PTR_STEP;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= csrf_pkg::CSRF_SER_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cnt_r   <= `CSRF_BIT_CNT_RESET;
      shift_r <= `CSRF_BYTE_ZERO;
      ptr_r   <= `CSRF_BYTE_ZERO;
      first_r <= 1'b1;
      rw_r    <= 1'b0;
      nack_r  <= 1'b0;
      oe_r    <= 1'b0;
      wr_r    <= 1'b0;
      waddr_r <= `CSRF_BYTE_ZERO;
      wdata_r <= `CSRF_BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r   <= ptr_nxt;
      first_r <= first_nxt;
      rw_r    <= rw_nxt;
      nack_r  <= nack_nxt;
      oe_r    <= oe_nxt;
      wr_r    <= wr_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe   = oe_r;
  assign wr_pulse = wr_r;
  assign wr_addr  = waddr_r;
  assign wr_data  = wdata_r;
  assign rd_addr  = ptr_r;

endmodule

// file: csrf_top.sv
/*
  Colour sensor register file: serial register access, clock, sleep and
  trim configuration, per-channel settings, and the request sequencer that
  hands measurements to the analog front end and captures its results.
  Assumes a front end that answers each request with a one-cycle done pulse.
*/
`timescale 1ns/1ps
`include "csrf_defs.svh"

module csrf_top #(
  parameter logic [6:0] DEV_ADDR = `CSRF_DEV_ADDR
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // Two-wire serial pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // Settings to the front end
  output csrf_pkg::csrf_setup_t      setup_r,
  // Front end handshake
  output logic                       fe_req_r,
  output logic                       fe_offset_r,
  input  wire logic                  fe_done,
  input  wire csrf_pkg::csrf_meas_t  fe_meas
);

  csrf_pkg::csrf_setup_t setup_nxt;
  csrf_pkg::csrf_meas_t  meas_r, meas_nxt;
  csrf_pkg::csrf_seq_t   seq_r, seq_nxt;
  logic                  conv_request_r, conv_request_nxt;
  logic                  offset_request_r, offset_request_nxt;
  logic                  fe_req_nxt;
  logic                  fe_offset_nxt;

  logic                  bus_wr;
  logic [7:0]            bus_waddr;
  logic [7:0]            bus_wdata;
  logic [7:0]            bus_raddr;
  logic [7:0]            bus_rdata;

  csrf_serial_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_serial (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .wr_pulse (bus_wr),
    .wr_addr  (bus_waddr),
    .wr_data  (bus_wdata),
    .rd_addr  (bus_raddr),
    .rd_data  (bus_rdata)
  );

  // Channel index is valid when the offset falls in a block of four
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base, input int c, input int step);
    in_block = (a == 8'(base + c * step));
  endfunction

  // Read view of every register
  function automatic logic [7:0] reg_read(
    input logic [7:0]            a,
    input csrf_pkg::csrf_setup_t s,
    input csrf_pkg::csrf_meas_t  m,
    input logic                  conv,
    input logic                  ofs
  );
    logic [7:0] v;
    v = `CSRF_BYTE_ZERO;
    if (a == `CSRF_ADDR_CMD) begin
      v[`CSRF_CMD_CONV_BIT] = conv;
      v[`CSRF_CMD_OFS_BIT]  = ofs;
    end
    if (a == `CSRF_ADDR_CFG) begin
      v[`CSRF_CFG_TRIM_BIT]  = s.trim;
      v[`CSRF_CFG_SLEEP_BIT] = s.sleep;
      v[`CSRF_CFG_EXT_BIT]   = s.ext_clk;
    end
    for (int c = 0; c < `CSRF_CHANNELS; c++) begin
      if (in_block(a, `CSRF_CAP_BASE, c, 1)) begin
        v[`CSRF_CAP_W-1:0] = s.cap[c];
      end
      if (in_block(a, `CSRF_INT_BASE, c, 2)) begin
        v = s.slots[c][7:0];
      end
      if (in_block(a, `CSRF_INT_BASE + 8'h01, c, 2)) begin
        v[`CSRF_SLOT_W-9:0] = s.slots[c][`CSRF_SLOT_W-1:8];
      end
      if (in_block(a, `CSRF_DATA_BASE, c, 2)) begin
        v = m.result[c][7:0];
      end
      if (in_block(a, `CSRF_DATA_BASE + 8'h01, c, 2)) begin
        v[`CSRF_RES_W-9:0] = m.result[c][`CSRF_RES_W-1:8];
      end
      if (in_block(a, `CSRF_OFS_BASE, c, 1)) begin
        v = m.offset[c];
      end
    end
    reg_read = v;
  endfunction

  assign bus_rdata = reg_read(bus_raddr, setup_r, meas_r, conv_request_r, offset_request_r);

  // Settings registers
  always_comb begin
    setup_nxt = setup_r;
    if (bus_wr) begin
      if (bus_waddr == `CSRF_ADDR_CFG) begin
        setup_nxt.ext_clk = bus_wdata[`CSRF_CFG_EXT_BIT];
        setup_nxt.trim    = bus_wdata[`CSRF_CFG_TRIM_BIT];
        setup_nxt.sleep   = bus_wdata[`CSRF_CFG_SLEEP_BIT];
      end
      for (int c = 0; c < `CSRF_CHANNELS; c++) begin
        if (in_block(bus_waddr, `CSRF_CAP_BASE, c, 1)) begin
          setup_nxt.cap[c] = bus_wdata[`CSRF_CAP_W-1:0];
        end
        if (in_block(bus_waddr, `CSRF_INT_BASE, c, 2)) begin
          setup_nxt.slots[c][7:0] = bus_wdata;
        end
        if (in_block(bus_waddr, `CSRF_INT_BASE + 8'h01, c, 2)) begin
          setup_nxt.slots[c][`CSRF_SLOT_W-1:8] = bus_wdata[`CSRF_SLOT_W-9:0];
        end
      end
    end
    setup_nxt.sleep = setup_nxt.sleep & setup_nxt.ext_clk;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      setup_r.ext_clk <= 1'b0;
      setup_r.sleep   <= 1'b0;
      setup_r.trim    <= 1'b0;
      for (int c = 0; c < `CSRF_CHANNELS; c++) begin
        setup_r.cap[c]   <= `CSRF_CAP_RESET;
        setup_r.slots[c] <= `CSRF_SLOT_RESET;
      end
    end else begin
      setup_r <= setup_nxt;
    end
  end

  // Request sequencer; requests wait while asleep, since the front end
  // has no clock then. Conversion goes first when both are pending.
  always_comb begin
    seq_nxt            = seq_r;
    meas_nxt           = meas_r;
    conv_request_nxt   = conv_request_r;
    offset_request_nxt = offset_request_r;
    fe_req_nxt         = fe_req_r;
    fe_offset_nxt      = fe_offset_r;
    unique case (seq_r)
      csrf_pkg::CSRF_SEQ_IDLE: begin
        if (!setup_r.sleep && conv_request_r) begin
          seq_nxt       = csrf_pkg::CSRF_SEQ_CONV;
          fe_req_nxt    = 1'b1;
          fe_offset_nxt = 1'b0;
        end else if (!setup_r.sleep && offset_request_r) begin
          seq_nxt       = csrf_pkg::CSRF_SEQ_OFS;
          fe_req_nxt    = 1'b1;
          fe_offset_nxt = 1'b1;
        end
      end
      csrf_pkg::CSRF_SEQ_CONV: begin
        if (fe_done) begin
          meas_nxt.result  = fe_meas.result;
          conv_request_nxt = 1'b0;
          fe_req_nxt       = 1'b0;
          seq_nxt          = csrf_pkg::CSRF_SEQ_IDLE;
        end
      end
      csrf_pkg::CSRF_SEQ_OFS: begin
        if (fe_done) begin
          meas_nxt.offset    = fe_meas.offset;
          offset_request_nxt = 1'b0;
          fe_req_nxt         = 1'b0;
          seq_nxt            = csrf_pkg::CSRF_SEQ_IDLE;
        end
      end
    endcase
    // Host write lands last so a fresh request is never lost
    if (bus_wr && bus_waddr == `CSRF_ADDR_CMD) begin
      conv_request_nxt   = bus_wdata[`CSRF_CMD_CONV_BIT];
      offset_request_nxt = bus_wdata[`CSRF_CMD_OFS_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      seq_r            <= csrf_pkg::CSRF_SEQ_IDLE;
      conv_request_r   <= 1'b0;
      offset_request_r <= 1'b0;
      fe_req_r         <= 1'b0;
      fe_offset_r      <= 1'b0;
      for (int c = 0; c < `CSRF_CHANNELS; c++) begin
        meas_r.result[c] <= `CSRF_RES_RESET;
        meas_r.offset[c] <= `CSRF_OFS_RESET;
      end
    end else begin
      seq_r            <= seq_nxt;
      conv_request_r   <= conv_request_nxt;
      offset_request_r <= offset_request_nxt;
      fe_req_r         <= fe_req_nxt;
      fe_offset_r      <= fe_offset_nxt;
      meas_r           <= meas_nxt;
    end
  end

endmodule

// file: csrf_top_monitor.sv
/*
  Checker for the colour sensor register file, watching only the ports of csrf_top.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module csrf_top_monitor (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // Serial pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  input  wire logic                  sda_out,
  input  wire logic                  sda_oe,
  // Front end
  input  wire csrf_pkg::csrf_setup_t setup_r,
  input  wire logic                  fe_req_r,
  input  wire logic                  fe_offset_r,
  input  wire logic                  fe_done,
  input  wire csrf_pkg::csrf_meas_t  fe_meas
);
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence run_busy;
    fe_req_r && !fe_done;
  endsequence

  sequence run_ends;
    fe_req_r && fe_done;
  endsequence

  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  sleep_ext_a: assert property (setup_r.sleep |-> setup_r.ext_clk)
    else $error("sleep held without external clock");
  run_drop_a: assert property (run_ends |=> !fe_req_r)
    else $error("request held after done");
  asleep_idle_a: assert property (!fe_req_r && setup_r.sleep |=> !fe_req_r)
    else $error("measurement started while asleep");
  kind_hold_a: assert property (run_busy ##1 fe_req_r |-> $stable(fe_offset_r))
    else $error("request kind changed mid-run");
  setup_quiet_a: assert property ($changed(setup_r) |-> !scl_in && !$past(scl_in))
    else $error("settings changed outside a write slot");
  ack_delay_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data line pulled too early");
  line_still_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  reset_vals_a: assert property ($rose(reset_n) |-> setup_r.cap == {4{4'hf}} && !fe_req_r)
    else $error("wrong state after reset");
endmodule

bind csrf_top csrf_top_monitor mon (
  .core_clk   (core_clk),
  .reset_n    (reset_n),
  .scl_in     (scl_in),
  .sda_in     (sda_in),
  .sda_out    (sda_out),
  .sda_oe     (sda_oe),
  .setup_r    (setup_r),
  .fe_req_r   (fe_req_r),
  .fe_offset_r(fe_offset_r),
  .fe_done    (fe_done),
  .fe_meas    (fe_meas)
);

// file: csrf_host_model.sv
/*
  Two-wire bus master standing in for the host processor.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps

module csrf_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter int         QTR      = 4
) (
  // Clock
  input  wire logic core_clk,
  // Serial lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic qtr();
    repeat (QTR) @(posedge core_clk);
  endtask

  // Data moves mid-low, sampled mid-high, well clear of the ack delay
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask

  task automatic start_c();
    sda_low <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask

  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop_c();
    ok = k1 & k2 & k3;
  endtask

  // Last byte answered with a release so the device ends the read
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3, k4;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    start_c();
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, k3);
    xfer(8'hff, 1'b1, d, k4);
    stop_c();
    ok = k1 & k2 & k3;
  endtask
endmodule

// file: csrf_top_bench.sv
/*
  Self-checking bench for csrf_top: host model on the serial pins, a simple
  front end answering requests. Assumes csrf_pkg and csrf_defs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "csrf_defs.svh"

module csrf_top_bench;
  logic                  core_clk = 1'b0;
  logic                  reset_n  = 1'b0;
  logic                  fe_done  = 1'b0;
  csrf_pkg::csrf_meas_t  fe_meas  = '0;
  logic                  scl_w, host_low, sda_out, sda_oe, fe_req_r, fe_offset_r;
  wire logic             sda_w;
  csrf_pkg::csrf_setup_t setup_r;
  int                    err_count = 0, checks_done = 0, cycles = 0, fe_delay = 40, fe_cnt = 0;

  always #2.5 core_clk = ~core_clk;
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~host_low;

  csrf_top dut (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .setup_r(setup_r), .fe_req_r(fe_req_r),
    .fe_offset_r(fe_offset_r), .fe_done(fe_done), .fe_meas(fe_meas));
  csrf_host_model #(.DEV_ADDR(`CSRF_DEV_ADDR)) host (.core_clk(core_clk), .sda(sda_w), .scl(scl_w),
    .sda_low(host_low));

  // Front end answers fe_delay+1 cycles after the request rises; timeout cuts a hang short
  always @(posedge core_clk) begin
    if (fe_req_r === 1'b1 && fe_done === 1'b0) begin
      fe_done <= (fe_cnt == fe_delay);
      fe_cnt <= fe_cnt + 1;
    end else begin
      fe_done <= 1'b0;
      fe_cnt <= 0;
    end
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      conclude();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: port value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(a, d, ok);
    check8({7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       ok;
    host.read_reg(a, q, ok);
    check8(q, exp);
  endtask

  // Bounded poll of a command bit until the device clears it
  task automatic poll(input logic [7:0] m);
    logic [7:0] q;
    logic       ok;
    int         n;
    n = 0;
    do begin
      host.read_reg(8'h00, q, ok);
      n++;
    end while ((q & m) !== 8'h00 && n < 20);
    check8(q & m, 8'h00);
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    for (int c = 0; c < 4; c++) begin
      rd_chk(8'h06 + 8'(c), 8'h0f);
      wr(8'h06 + 8'(c), {4'hf, 4'(c * 5)});
      rd_chk(8'h06 + 8'(c), {4'h0, 4'(c * 5)});
      check16({12'h000, setup_r.cap[c]}, {12'h000, 4'(c * 5)});
      wr(8'h0a + 8'(2 * c), 8'h81 + 8'(c));
      wr(8'h0b + 8'(2 * c), {4'hf, 4'(c + 8)});
      rd_chk(8'h0b + 8'(2 * c), {4'h0, 4'(c + 8)});
      check16({4'h0, setup_r.slots[c]}, {4'h0, 4'(c + 8), 8'h81 + 8'(c)});
    end
    // Sleep asked for without external clock must not stick
    wr(8'h01, 8'hfb);
    rd_chk(8'h01, 8'h01);
    check16({13'h0000, setup_r.ext_clk, setup_r.sleep, setup_r.trim}, 16'h0001);
    wr(8'h01, 8'h06);
    rd_chk(8'h01, 8'h06);
    check16({13'h0000, setup_r.ext_clk, setup_r.sleep, setup_r.trim}, 16'h0006);
    // Request made while asleep waits for the wake-up write
    wr(8'h00, 8'h01);
    rd_chk(8'h00, 8'h01);
    check16({14'h0000, fe_req_r, fe_offset_r}, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      fe_meas.result[c] <= {2'(3 - c), 8'h5a + 8'(c)};
      fe_meas.offset[c] <= 8'hee;
    end
    wr(8'h01, 8'h00);
    check16({14'h0000, fe_req_r, fe_offset_r}, 16'h0002);
    poll(8'h01);
    for (int c = 0; c < 4; c++) begin
      fe_meas.result[c] <= 10'h000;
      fe_meas.offset[c] <= {1'(c), 7'(c * 9 + 1)};
    end
    wr(8'h00, 8'h02);
    check16({14'h0000, fe_req_r, fe_offset_r}, 16'h0003);
    poll(8'h02);
    for (int c = 0; c < 4; c++) begin
      rd_chk(8'h40 + 8'(2 * c), 8'h5a + 8'(c));
      rd_chk(8'h41 + 8'(2 * c), {6'h00, 2'(3 - c)});
      rd_chk(8'h48 + 8'(c), {1'(c), 7'(c * 9 + 1)});
    end
    wr(8'h48, 8'h55);
    rd_chk(8'h48, 8'h01);
    rd_chk(8'h20, 8'h00);
    conclude();
  end
endmodule
